// ---- hdl/mmu_cfg.svh ----
// offsets, field positions, reset values and codes of the mmu check block
`ifndef MMU_CFG_SVH
`define MMU_CFG_SVH
// register indices; byte address is four times the index
`define IDX_CTRL      10'h001
`define IDX_TABLE     10'h002
`define IDX_DOMAIN    10'h003
`define IDX_FSTATUS   10'h005
`define IDX_FADDR     10'h006
// control register fields
`define CTRL_MMU      0
`define CTRL_ALIGN    1
`define CTRL_CACHE    2
`define CTRL_WBUF     3
`define CTRL_SYS      8
// reset values
`define CTRL_RST      32'h0000_0000
`define TABLE_RST     32'h0000_0000
`define DOMAIN_RST    32'h0000_0000
// descriptor type codes, bits 1:0
`define DESC_FAULT    2'h0
`define DESC_PAGE     2'h1
`define DESC_SECTION  2'h2
`define DESC_LARGE    2'h1
`define DESC_SMALL    2'h2
// domain field and permission codes
`define DOM_CLIENT    2'h1
`define DOM_MANAGER   2'h3
`define PC_NONE       2'h0
`define PC_SUPER      2'h1
`define PC_UREAD      2'h2
`define PC_ALL        2'h3
// fault source codes
`define FS_WBUF       4'h0
`define FS_ALIGN      4'h1
`define FS_LF_SEC     4'h4
`define FS_TR_SEC     4'h5
`define FS_LF_PG      4'h6
`define FS_TR_PG      4'h7
`define FS_OT_SEC     4'h8
`define FS_DOM_SEC    4'h9
`define FS_OT_PG      4'hA
`define FS_DOM_PG     4'hB
`define FS_L1_BUS     4'hC
`define FS_PERM_SEC   4'hD
`define FS_L2_BUS     4'hE
`define FS_PERM_PG    4'hF
`endif

// ---- hdl/mmu_pkg.sv ----
// types shared by the mmu check block
package mmu_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_L1, ST_L2, ST_DONE} walk_state_e;

   typedef struct packed {
      logic [31:0] vaddr;
      logic        write;
      logic        user;
      logic        word;
      logic        ifetch;
   } acc_req_s;

   typedef struct packed {
      logic [31:0] paddr;
      logic        cacheable;
      logic        bufferable;
      logic        updateable;
      logic        abort;
      logic [3:0]  fs;
   } acc_resp_s;
endpackage : mmu_pkg

// ---- hdl/perm_eval.sv ----
// domain and access permission evaluation for one access
`timescale 1ns/1ps
`include "mmu_cfg.svh"
module perm_eval (
   // clock and reset, for checks only
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // access and attributes
   input  wire logic [1:0] dom_field,
   input  wire logic [1:0] access_perm_code,
   input  wire logic       sys_prot,
   input  wire logic       user,
   input  wire logic       write,
   // result
   output logic            domain_fault,
   output logic            perm_fault
);
   logic ok;

   always_comb begin
      domain_fault = (dom_field != `DOM_CLIENT) && (dom_field != `DOM_MANAGER); // [RULE23]
      unique case (access_perm_code)
         `PC_NONE:  ok = sys_prot && !user && !write; // [RULE6]
         `PC_SUPER: ok = !user;                      // [RULE7]
         `PC_UREAD: ok = !user || !write;            // [RULE8]
         `PC_ALL:   ok = 1'b1;                       // [RULE9]
      endcase
      perm_fault = (dom_field == `DOM_CLIENT) && !ok; // [RULE5]
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_pc_none;
      dom_field == `DOM_CLIENT && access_perm_code == `PC_NONE
         && (user || write || !sys_prot) |-> perm_fault;
   endproperty
   a_pc_none: assert property (p_pc_none) else $error("code 00 access allowed"); // [RULE6]
   property p_pc_super;
      dom_field == `DOM_CLIENT && access_perm_code == `PC_SUPER |-> perm_fault == user;
   endproperty
   a_pc_super: assert property (p_pc_super) else $error("code 01 wrong result"); // [RULE7]
   property p_pc_uread;
      dom_field == `DOM_CLIENT && access_perm_code == `PC_UREAD |-> perm_fault == (user && write);
   endproperty
   a_pc_uread: assert property (p_pc_uread) else $error("code 10 wrong result"); // [RULE8]
   property p_pc_all;
      access_perm_code == `PC_ALL |-> !perm_fault;
   endproperty
   a_pc_all: assert property (p_pc_all) else $error("code 11 faulted"); // [RULE9]
   property p_domain;
      dom_field[0] == 1'b0 |-> domain_fault && !perm_fault;
   endproperty
   a_domain: assert property (p_domain) else $error("no access domain passed"); // [RULE23]
endmodule : perm_eval

// ---- hdl/mmu_check.sv ----
// mmu descriptor decode, permission check and fault recording
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "mmu_cfg.svh"
// Behaviour
// RULE1: section bits 4:2 are update, cache, buffer
// RULE2: updateable section updates cache on writes
// RULE3: cache and buffer flags gated by enables
// RULE4: section bits 8:5 select one domain
// RULE5: permission bits 11:10 apply in client only
// RULE6: code 00 faults all, S allows supervisor read
// RULE7: code 01 supervisor only
// RULE8: code 10 user reads, supervisor all
// RULE9: code 11 allows everything
// RULE10: section base from bits 31:20
// RULE11: check permissions before physical address
// RULE12: page descriptor 00 faults, 01 large, 10 small
// RULE13: page bit 2 buffer, bit 3 cache
// RULE14: four sub-page permission fields, bits 11:4
// RULE15: page number bits 31:12 small, 31:16 large
// RULE16: software repeats large entries sixteen times
// RULE17: alignment, translation, domain, permission faults abort
// RULE18: internal faults suppress the external access
// RULE19: data abort stores status, domain, address
// RULE20: prefetch abort only tags, registers unchanged
// RULE21: tag aborts on execution, dropped on discard
// RULE22: coinciding aborts reported by priority
// RULE23: domain 00/10 fault, 01 check, 11 bypass
// RULE24: first level 00 faults, 01 page, 10 section
// RULE25: first level address from base and address
// RULE26: low virtual bits pass as offset
module mmu_check (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               reset_n,
   // register bus
   input  wire logic [11:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // access from the core
   input  wire logic               acc_valid,
   input  wire mmu_pkg::acc_req_s  acc,
   output logic                    acc_busy,
   output logic                    resp_valid,
   output mmu_pkg::acc_resp_s      resp,
   output logic                    mem_start,
   // instruction pipeline
   input  wire logic               insn_execute,
   input  wire logic               insn_discard,
   output logic                    prefetch_abort,
   // descriptor fetch
   output logic                    desc_req,
   output logic      [31:0]        desc_addr,
   input  wire logic               desc_valid,
   input  wire logic [31:0]        desc_data,
   input  wire logic               desc_err,
   // external aborts
   input  wire logic               ext_abort,
   input  wire logic               ext_linefetch,
   input  wire logic               wbuf_error
);
   import mmu_pkg::*;

   logic [31:0] ctrl_q;
   logic [31:0] table_base_reg_q;
   logic [31:0] domain_reg_q;
   logic [7:0]  fault_status_reg_q;
   logic [31:0] fault_address_reg_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   walk_state_e state_q;
   acc_req_s    acc_q;
   logic [31:0] l1_q;
   logic [31:0] l2_q;
   logic        pend_q;
   logic [3:0]  pfs_q;
   logic        page_q;
   logic        flat_q;
   logic        desc_req_q;
   logic [31:0] desc_addr_q;
   acc_resp_s   resp_q;
   logic        resp_valid_q;
   logic        mem_start_q;
   logic        acc_busy_q;
   logic        tag_q;
   logic        prefetch_abort_q;

   logic [9:0]  reg_idx;
   logic        hit_c;
   logic [31:0] rdata_c;
   logic        align_c;
   logic [3:0]  dom_c;
   logic [1:0]  dom_field_c;
   logic        large_c;
   logic [1:0]  sp_sel_c;
   logic [1:0]  perm_c;
   logic        domain_fault_c;
   logic        perm_fault_c;
   logic        done_fault_c;
   logic [3:0]  done_fs_c;
   logic [7:0]  done_fsr_c;
   logic [31:0] paddr_c;
   logic        tag_set_c;

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign desc_req       = desc_req_q;
   assign desc_addr      = desc_addr_q;
   assign resp           = resp_q;
   assign resp_valid     = resp_valid_q;
   assign mem_start      = mem_start_q;
   assign acc_busy       = acc_busy_q;
   assign prefetch_abort = prefetch_abort_q;

   // register decode
   always_comb begin
      reg_idx = paddr[11:2];
      hit_c   = 1'b1;
      rdata_c = 32'h0000_0000;
      unique case (reg_idx)
         `IDX_CTRL:    rdata_c = ctrl_q;
         `IDX_TABLE:   rdata_c = table_base_reg_q;
         `IDX_DOMAIN:  rdata_c = domain_reg_q;
         `IDX_FSTATUS: rdata_c = {24'h00_0000, fault_status_reg_q};
         `IDX_FADDR:   rdata_c = fault_address_reg_q;
         default:      hit_c   = 1'b0;
      endcase
   end

   // answer in the first access cycle, data sampled at setup
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= psel && !penable;
         pslverr_q <= psel && !penable && !hit_c;
         prdata_q  <= (psel && !penable && !pwrite) ? rdata_c : 32'h0000_0000;
      end
   end

   // software registers; table base keeps a 16Kb boundary
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q           <= `CTRL_RST;
         table_base_reg_q <= `TABLE_RST;
         domain_reg_q     <= `DOMAIN_RST;
      end else if (psel && penable && pready_q && pwrite) begin
         if (reg_idx == `IDX_CTRL)
            ctrl_q <= pwdata;
         if (reg_idx == `IDX_TABLE)
            table_base_reg_q <= {pwdata[31:14], 14'h0000};
         if (reg_idx == `IDX_DOMAIN)
            domain_reg_q <= pwdata;
      end
   end

   // check of the fetched descriptors
   always_comb begin
      align_c = ctrl_q[`CTRL_ALIGN] && acc.word && !acc.ifetch
                && (acc.vaddr[1:0] != 2'h0); // [RULE17]
      dom_c       = l1_q[8:5]; // [RULE4]
      dom_field_c = domain_reg_q[{dom_c, 1'b0} +: 2]; // [RULE4]
      large_c     = l2_q[1:0] == `DESC_LARGE;
      sp_sel_c    = large_c ? acc_q.vaddr[15:14] : acc_q.vaddr[11:10];
      perm_c = page_q ? l2_q[{sp_sel_c, 1'b0} + 4'h4 +: 2] : l1_q[11:10]; // [RULE14] [RULE5]
   end

   perm_eval u_perm (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .dom_field    (dom_field_c),
      .access_perm_code (perm_c),
      .sys_prot     (ctrl_q[`CTRL_SYS]),
      .user         (acc_q.user),
      .write        (acc_q.write),
      .domain_fault (domain_fault_c),
      .perm_fault   (perm_fault_c)
   );

   always_comb begin
      done_fault_c = pend_q || (!flat_q && (domain_fault_c || perm_fault_c)); // [RULE17]
      if (pend_q)
         done_fs_c = pfs_q;
      else if (domain_fault_c)
         done_fs_c = page_q ? `FS_DOM_PG : `FS_DOM_SEC;
      else
         done_fs_c = page_q ? `FS_PERM_PG : `FS_PERM_SEC;
      done_fsr_c = {dom_c, done_fs_c};
      if (flat_q)
         paddr_c = acc_q.vaddr;
      else if (!page_q)
         paddr_c = {l1_q[31:20], acc_q.vaddr[19:0]}; // [RULE10] [RULE26]
      else if (large_c)
         paddr_c = {l2_q[31:16], acc_q.vaddr[15:0]}; // [RULE15] [RULE26]
      else
         paddr_c = {l2_q[31:12], acc_q.vaddr[11:0]}; // [RULE15] [RULE26]
   end

   // table walk
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q     <= ST_IDLE;
         acc_q       <= '0;
         l1_q        <= 32'h0000_0000;
         l2_q        <= 32'h0000_0000;
         pend_q      <= 1'b0;
         pfs_q       <= 4'h0;
         page_q      <= 1'b0;
         flat_q      <= 1'b0;
         desc_req_q  <= 1'b0;
         desc_addr_q <= 32'h0000_0000;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (acc_valid) begin
                  acc_q  <= acc;
                  pend_q <= 1'b0;
                  page_q <= 1'b0;
                  flat_q <= !ctrl_q[`CTRL_MMU];
                  l1_q   <= 32'h0000_0000;
                  l2_q   <= 32'h0000_0000;
                  if (align_c) begin
                     pend_q  <= 1'b1; // [RULE17]
                     pfs_q   <= `FS_ALIGN;
                     state_q <= ST_DONE;
                  end else if (!ctrl_q[`CTRL_MMU]) begin
                     state_q <= ST_DONE;
                  end else begin
                     desc_req_q  <= 1'b1;
                     desc_addr_q <= {table_base_reg_q[31:14], acc.vaddr[31:20], 2'h0}; // [RULE25]
                     state_q     <= ST_L1;
                  end
               end
            end
            ST_L1: begin
               if (desc_valid) begin
                  desc_req_q <= 1'b0;
                  l1_q       <= desc_data;
                  if (desc_err) begin
                     pend_q  <= 1'b1;
                     pfs_q   <= `FS_L1_BUS;
                     state_q <= ST_DONE;
                  end else if (desc_data[1:0] == `DESC_PAGE) begin
                     page_q      <= 1'b1; // [RULE24]
                     desc_req_q  <= 1'b1;
                     desc_addr_q <= {desc_data[31:10], acc_q.vaddr[19:12], 2'h0};
                     state_q     <= ST_L2;
                  end else begin
                     if (desc_data[1:0] != `DESC_SECTION) begin
                        pend_q <= 1'b1; // [RULE24]
                        pfs_q  <= `FS_TR_SEC;
                     end
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_L2: begin
               if (desc_valid) begin
                  desc_req_q <= 1'b0;
                  l2_q       <= desc_data;
                  if (desc_err) begin
                     pend_q <= 1'b1;
                     pfs_q  <= `FS_L2_BUS;
                  end else if (desc_data[1:0] != `DESC_LARGE
                               && desc_data[1:0] != `DESC_SMALL) begin
                     pend_q <= 1'b1; // [RULE12]
                     pfs_q  <= `FS_TR_PG;
                  end
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // answer to the core; address only for a checked access
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         resp_q       <= '0;
         resp_valid_q <= 1'b0;
         mem_start_q  <= 1'b0;
         acc_busy_q   <= 1'b0;
      end else begin
         acc_busy_q   <= (state_q == ST_IDLE) ? acc_valid : (state_q != ST_DONE);
         resp_valid_q <= state_q == ST_DONE;
         mem_start_q  <= (state_q == ST_DONE) && !done_fault_c; // [RULE18]
         if (state_q == ST_DONE) begin
            resp_q.abort <= done_fault_c; // [RULE17]
            resp_q.fs    <= done_fault_c ? done_fs_c : 4'h0;
            resp_q.paddr <= done_fault_c ? 32'h0000_0000 : paddr_c; // [RULE11]
            resp_q.cacheable <= !done_fault_c && !flat_q && ctrl_q[`CTRL_CACHE]
                                && (page_q ? l2_q[3] : l1_q[3]); // [RULE1] [RULE3] [RULE13]
            resp_q.bufferable <= !done_fault_c && !flat_q && ctrl_q[`CTRL_WBUF]
                                 && (page_q ? l2_q[2] : l1_q[2]); // [RULE1] [RULE3] [RULE13]
            resp_q.updateable <= !done_fault_c && !flat_q && !page_q && l1_q[4]
                                 && ctrl_q[`CTRL_CACHE] && acc_q.write; // [RULE1] [RULE2]
         end
      end
   end

   // fault status and address, highest source first
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_status_reg_q  <= 8'h00;
         fault_address_reg_q <= 32'h0000_0000;
      end else if (wbuf_error) begin
         fault_status_reg_q <= {4'h0, `FS_WBUF}; // [RULE22]
      end else if (ext_abort && !acc_q.ifetch) begin
         fault_address_reg_q <= acc_q.vaddr;
         if (ext_linefetch)
            fault_status_reg_q <= {dom_c, page_q ? `FS_LF_PG : `FS_LF_SEC}; // [RULE22]
         else
            fault_status_reg_q <= {dom_c, page_q ? `FS_OT_PG : `FS_OT_SEC}; // [RULE22]
      end else if (state_q == ST_DONE && done_fault_c && !acc_q.ifetch) begin
         fault_status_reg_q  <= done_fsr_c; // [RULE19]
         fault_address_reg_q <= acc_q.vaddr; // [RULE19]
      end
   end

   // prefetch abort tag travels with the fetched instruction
   assign tag_set_c = acc_q.ifetch
                      && ((state_q == ST_DONE && done_fault_c) || ext_abort); // [RULE20]

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tag_q            <= 1'b0;
         prefetch_abort_q <= 1'b0;
      end else begin
         tag_q            <= tag_set_c || (tag_q && !insn_discard && !insn_execute); // [RULE21]
         prefetch_abort_q <= insn_execute && tag_q; // [RULE21]
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_l1_addr;
      state_q == ST_L1 |-> desc_addr_q == {table_base_reg_q[31:14], acc_q.vaddr[31:20], 2'h0};
   endproperty
   a_l1_addr: assert property (p_l1_addr) else $error("first level address wrong"); // [RULE25]
   property p_sec_paddr;
      resp_valid_q && !resp_q.abort && !flat_q && !page_q
         |-> resp_q.paddr == {l1_q[31:20], acc_q.vaddr[19:0]};
   endproperty
   a_sec_paddr: assert property (p_sec_paddr) else $error("section address wrong"); // [RULE10]
   property p_small_paddr;
      resp_valid_q && !resp_q.abort && page_q && l2_q[1:0] == `DESC_SMALL
         |-> resp_q.paddr == {l2_q[31:12], acc_q.vaddr[11:0]};
   endproperty
   a_small_paddr: assert property (p_small_paddr) else $error("small page address wrong"); // [RULE15]
   property p_no_start;
      resp_valid_q && resp_q.abort |-> !mem_start_q;
   endproperty
   a_no_start: assert property (p_no_start) else $error("faulted access started"); // [RULE18]
   property p_align;
      state_q == ST_IDLE && acc_valid && align_c
         |-> ##2 resp_valid_q && resp_q.abort && resp_q.fs == `FS_ALIGN;
   endproperty
   a_align: assert property (p_align) else $error("alignment fault missing"); // [RULE17]
   property p_pf_keep;
      state_q == ST_DONE && acc_q.ifetch && !wbuf_error
         |=> $stable(fault_status_reg_q) && $stable(fault_address_reg_q);
   endproperty
   a_pf_keep: assert property (p_pf_keep) else $error("prefetch changed fault regs"); // [RULE20]
   property p_data_fsr;
      state_q == ST_DONE && done_fault_c && !acc_q.ifetch && !wbuf_error && !ext_abort
         |=> fault_status_reg_q == $past(done_fsr_c)
             && fault_address_reg_q == $past(acc_q.vaddr);
   endproperty
   a_data_fsr: assert property (p_data_fsr) else $error("data abort not recorded"); // [RULE19]
   property p_tag;
      insn_execute && tag_q |=> prefetch_abort_q;
   endproperty
   a_tag: assert property (p_tag) else $error("tagged instruction not aborted"); // [RULE21]
   property p_drop;
      insn_discard && !tag_set_c |=> !tag_q ##1 !prefetch_abort_q;
   endproperty
   a_drop: assert property (p_drop) else $error("discarded tag kept"); // [RULE21]
   property p_cache;
      resp_valid_q && (resp_q.cacheable || resp_q.updateable) |-> ctrl_q[`CTRL_CACHE];
   endproperty
   a_cache: assert property (p_cache) else $error("cache flag without enable"); // [RULE3]
endmodule : mmu_check

// ---- test/desc_mem_model.sv ----
// translation table memory that answers the block's descriptor fetches
`timescale 1ns/1ps
module desc_mem_model (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // fetch port
   input  wire logic        desc_req,
   input  wire logic [31:0] desc_addr,
   input  wire logic [1:0]  dly,
   output logic             desc_valid,
   output logic [31:0]      desc_data,
   output logic             desc_err
);
   logic [31:0] mem [logic [31:0]];
   logic [1:0]  wait_q;
   // unwritten words give a bus error
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {desc_valid, desc_err, desc_data, wait_q} <= '0;
      end else if (desc_req && !desc_valid && wait_q == dly) begin
         desc_valid <= 1'b1;
         desc_err   <= !mem.exists(desc_addr);
         desc_data  <= mem.exists(desc_addr) ? mem[desc_addr] : ~desc_data;
         wait_q     <= 2'h0;
      end else begin
         {desc_valid, desc_err} <= 2'h0;
         desc_data  <= ~desc_data;
         wait_q     <= (desc_req && !desc_valid) ? wait_q + 2'h1 : 2'h0;
      end
   end
endmodule : desc_mem_model

// ---- test/mmu_check_tb.sv ----
// self-checking bench for the mmu check block
`timescale 1ns/1ps
`include "mmu_cfg.svh"
module mmu_check_tb;
   import mmu_pkg::*;
   typedef struct packed {
      logic [3:0]  f;
      logic [1:0]  perm;
      logic [3:0]  dom;
      logic [2:0]  ucb;
      logic [1:0]  ty;
      logic [3:0]  code;
   } row_s;
   localparam logic [31:0] TB = 32'h0001_0000;
   localparam logic [31:0] PT = 32'h0002_0000;
   localparam logic [31:0] PL = 32'h0003_0000;
   localparam logic [1:0]  S  = `DESC_SECTION;
   localparam logic [3:0]  FP = `FS_PERM_SEC;
   // f: write, user, word, ifetch; code 0: no abort; row i maps index i + 1
   localparam row_s ROWS [11] = '{
      '{4'h2, 2'h0, 4'h0, 3'h7, S, FP}, '{4'ha, 2'h1, 4'h0, 3'h7, S, 4'h0},
      '{4'h6, 2'h1, 4'h0, 3'h2, S, FP}, '{4'h6, 2'h2, 4'h0, 3'h4, S, 4'h0},
      '{4'he, 2'h2, 4'h0, 3'h1, S, FP}, '{4'he, 2'h3, 4'h0, 3'h3, S, 4'h0},
      '{4'he, 2'h0, 4'h1, 3'h0, S, 4'h0}, '{4'h2, 2'h3, 4'h2, 3'h0, S, `FS_DOM_SEC},
      '{4'h2, 2'h3, 4'h3, 3'h0, S, `FS_DOM_SEC}, '{4'h2, 2'h3, 4'h0, 3'h0, 2'h0, `FS_TR_SEC},
      '{4'h2, 2'h3, 4'h0, 3'h0, 2'h3, `FS_TR_SEC}};
   logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, er, st;
   logic        acc_valid, acc_busy, resp_valid, mem_start, insn_execute, insn_discard, wbuf_error;
   logic        prefetch_abort, desc_req, desc_valid, desc_err, ext_abort, ext_linefetch;
   logic [1:0]  dly;
   logic [11:0] paddr, ix;
   logic [31:0] pwdata, prdata, desc_addr, desc_data, rd, va, d;
   acc_req_s    acc;
   acc_resp_s   resp, got;
   row_s        r;
   int          n_fail, num_checks;
   mmu_check mmu_check_inst (
      .core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acc_valid(acc_valid), .acc(acc), .acc_busy(acc_busy), .resp_valid(resp_valid),
      .resp(resp), .mem_start(mem_start), .insn_execute(insn_execute),
      .insn_discard(insn_discard), .prefetch_abort(prefetch_abort), .desc_req(desc_req),
      .desc_addr(desc_addr), .desc_valid(desc_valid), .desc_data(desc_data),
      .desc_err(desc_err), .ext_abort(ext_abort), .ext_linefetch(ext_linefetch),
      .wbuf_error(wbuf_error));
   desc_mem_model desc_mem_model_inst (
      .core_clk(core_clk), .reset_n(reset_n), .desc_req(desc_req), .desc_addr(desc_addr),
      .dly(dly), .desc_valid(desc_valid), .desc_data(desc_data), .desc_err(desc_err));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic put(input logic [31:0] a, v);
      desc_mem_model_inst.mem[a] = v;
   endtask : put
   task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] wd);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) n_fail++;
      if (n >= 20) complete_run();
      @(posedge core_clk);
   endtask : apb
   task automatic access(input logic [31:0] a, input logic [3:0] f);
      int n = 0;
      acc_valid <= 1'b1;
      acc <= {a, f};
      @(posedge core_clk);
      acc_valid <= 1'b0;
      @(posedge core_clk);
      chk("busy", acc_busy, 1'b1);
      do begin
         @(posedge core_clk);
         n++;
      end while (resp_valid !== 1'b1 && n < 50);
      got = resp;
      st = mem_start;
      if (n >= 50) n_fail++;
      if (n >= 50) complete_run();
   endtask : access
   task automatic flt(input logic [31:0] a, input logic [7:0] ds);
      apb(1'b0, `IDX_FSTATUS, '0);
      chk("fstat", rd, {24'h0, ds});
      apb(1'b0, `IDX_FADDR, '0);
      chk("faddr", rd, a);
   endtask : flt
   task automatic exec(input logic disc);
      insn_discard <= disc;
      @(posedge core_clk);
      insn_discard <= 1'b0;
      insn_execute <= 1'b1;
      @(posedge core_clk);
      insn_execute <= 1'b0;
      @(posedge core_clk);
      chk("pabort", prefetch_abort, !disc);
   endtask : exec
   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, acc_valid, insn_execute, insn_discard} = '0;
      {ext_abort, ext_linefetch, wbuf_error, paddr, pwdata, acc, dly} = '0;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      apb(1'b0, `IDX_CTRL, '0);
      chk("ctrl", rd, `CTRL_RST);
      apb(1'b0, 10'h3ff, '0);
      chk("slverr", er, 1'b1);
      apb(1'b1, `IDX_CTRL, 32'h0000_000f);
      apb(1'b1, `IDX_TABLE, TB);
      apb(1'b1, `IDX_DOMAIN, 32'h0000_048d);
      foreach (ROWS[i]) begin
         r = ROWS[i];
         ix = 12'(i + 1);
         va = {ix, 20'h0_05a4};
         d = {ix ^ 12'h800, 8'h00, r.perm, 1'b0, r.dom, r.ucb, r.ty};
         put({TB[31:14], ix, 2'h0}, d);
         dly <= i[1:0];
         access(va, r.f);
         chk("abort", got.abort, r.code != 4'h0);
         chk("start", st, r.code == 4'h0);
         if (r.code != 4'h0) begin
            flt(va, {r.dom, r.code});
         end else begin
            chk("paddr", got.paddr, {d[31:20], va[19:0]});
            chk("attr", {got.updateable, got.cacheable, got.bufferable},
                {r.ucb[2] & r.f[3], r.ucb[1:0]});
         end
         $display("row %0d done", i);
      end
      dly <= 2'h1;
      apb(1'b1, `IDX_CTRL, 32'h0000_010f);
      put({TB[31:14], 12'h00c, 2'h0}, 32'h3210_0002);
      access(32'h00c0_0100, 4'h2);
      chk("sys_read", got.abort, 1'b0);
      access(32'h00c0_0100, 4'ha);
      chk("sys_write", got.fs, `FS_PERM_SEC);
      apb(1'b1, `IDX_CTRL, 32'h0000_000f);
      put({TB[31:14], 12'h010, 2'h0}, {PT[31:10], 1'b0, 4'h5, 5'h01});
      put({PT[31:10], 8'h34, 2'h0}, {20'habcde, 8'he4, 4'ha});
      access(32'h0103_4c40, 4'he);
      chk("small_paddr", got.paddr, 32'habcd_ec40);
      chk("small_attr", {got.cacheable, got.bufferable}, 2'h2);
      access(32'h0103_4840, 4'he);
      flt(32'h0103_4840, {4'h5, `FS_PERM_PG});
      put({TB[31:14], 12'h011, 2'h0}, {PL[31:10], 1'b0, 4'h5, 5'h01});
      for (int k = 0; k < 16; k++) begin
         put({PL[31:10], 4'h5, k[3:0], 2'h0}, 32'h1234_00c5);
      end
      access(32'h0115_7abc, 4'he);
      chk("large_paddr", got.paddr, 32'h1234_7abc);
      chk("large_attr", {got.cacheable, got.bufferable}, 2'h1);
      access(32'h0116_0abc, 4'h2);
      flt(32'h0116_0abc, {4'h5, `FS_L2_BUS});
      put({PL[31:10], 8'h60, 2'h0}, 32'h0000_0000);
      access(32'h0116_0abc, 4'h2);
      flt(32'h0116_0abc, {4'h5, `FS_TR_PG});
      access(32'h3ff0_0000, 4'h2);
      chk("l1_bus", got.fs, `FS_L1_BUS);
      access(32'h0000_0102, 4'h2);
      chk("align", got.fs, `FS_ALIGN);
      access(32'h0080_0000, 4'h3);
      chk("pf_abort", got.abort, 1'b1);
      flt(32'h0000_0102, {4'h0, `FS_ALIGN});
      exec(1'b0);
      access(32'h0080_0000, 4'h3);
      exec(1'b1);
      wbuf_error <= 1'b1;
      @(posedge core_clk);
      wbuf_error <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, `IDX_FSTATUS, '0);
      chk("wbuf_code", rd[3:0], `FS_WBUF);
      $display("hand tests done");
      complete_run();
   end
endmodule : mmu_check_tb
